// file: pkg/smb_cfg.svh
/*
 * Location map, factory defaults and timing figures of the sensor memory bus slave.
 * Assumes it is included by bare name before the package and the design module.
 */
`ifndef SMB_CFG_SVH
`define SMB_CFG_SVH

// Memory locations, volatile ones and the stored bus address first, nonvolatile parameters from 0x20 upward.
`define SMB_LOC_CAL 8'h00
`define SMB_LOC_RAW 8'h01
`define SMB_LOC_TEMP 8'h02
`define SMB_LOC_DOUT 8'h03
`define SMB_LOC_ADDR 8'h04
`define SMB_LOC_RESTORE 8'h05
`define SMB_LOC_LOWTHR 8'h20
`define SMB_LOC_HIGHTHR 8'h21
`define SMB_LOC_HYSTERESIS 8'h22
`define SMB_LOC_INV 8'h23
`define SMB_LOC_OFFSET 8'h24

// Bus addresses, eight bits with the read/write bit position included.
`define SMB_ALT_ADDR 8'h10
`define SMB_DEF_ADDR 8'h48

// Factory parameter values and special codes.
`define SMB_DEF_LOWTHR 8'h64
`define SMB_DEF_HIGHTHR 8'hff
`define SMB_DEF_HYSTERESIS 8'h0a
`define SMB_DEF_INV 8'h00
`define SMB_DEF_OFFSET 8'h00
`define SMB_UNMAPPED 8'hff
`define SMB_RESTORE_KEY 8'h01
`define SMB_RESTORE_READ 8'h00
`define SMB_LATCH_HYSTERESIS 8'hff
`define SMB_WINDOW_OFF 8'hff
`define SMB_PTR_RESET 8'h00

// Link framing and power-up strap timing.
`define SMB_BITS 4'h8
`define SMB_STRAP_WAIT 2'h2

// Core rate 40000 kHz, fastest bus rate 400 kHz, and the worst handshake in core cycles.
`define SMB_CORE_KHZ 32'h0000_9c40
`define SMB_BUS_MAX_KHZ 32'h0000_0190
`define SMB_BIT_CYCLES (`SMB_CORE_KHZ / `SMB_BUS_MAX_KHZ)
`define SMB_XFER_CYCLES 32'h0000_0008

`endif

// file: pkg/smb_pkg.sv
/*
 * Types of the sensor memory bus slave: link states and the state records.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package smb_pkg;

    // Link protocol states.
    typedef enum logic [2:0] {
        LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_WR, LK_WR_ACK, LK_RD, LK_RD_ACK
    } smb_link_e;

    // Nonvolatile parameters; they survive the power-up reset.
    typedef struct packed {
        logic [7:0] busAddr;
        logic [7:0] lowThr;
        logic [7:0] highThr;
        logic [7:0] hysteresis;
        logic [7:0] invert;
        logic [7:0] offset;
    } smb_nv_s;

    // Core-domain volatile state.
    typedef struct packed {
        logic [1:0] strapSync;
        logic [1:0] strapWait;
        logic strapHigh;
        logic cfgReady;
        logic [7:0] activeAddr;
        logic [2:0] wrSync;
        logic [2:0] rdSync;
        logic rdAck;
        logic [7:0] rdData;
        logic [7:0] ptr;
        logic doutState;
        logic doutPin;
    } smb_core_s;

    // Link-domain state.
    typedef struct packed {
        smb_link_e st;
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic sclQ;
        logic sdaQ;
        logic [1:0] rdySync;
        logic [2:0] ackSync;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [7:0] rdHold;
        logic [3:0] cnt;
        logic firstByte;
        logic wrReq;
        logic wrKind;
        logic [7:0] wrByte;
        logic rdReq;
        logic sdaOut;
        logic sdaOe;
    } smb_link_s;

endpackage

// file: hw/smb_sensor_bus_slave.sv
/*
 * Two-wire bus slave of a magnetic field sensor: bus address selection, active memory
 * pointer, single-byte location reads and writes, parameter store and digital output.
 * Assumes the bus pins arrive asynchronously, a free link clock at least ten times the
 * bus rate oversamples them, and measurement bytes come from core_clk logic.
 */
`timescale 1ns/100ps

`include "smb_cfg.svh"

module smb_sensor_bus_slave (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic nvRstn,
    input wire logic linkClk,
    input wire logic addrSelPin,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [7:0] calField,
    input wire logic [7:0] rawField,
    input wire logic [7:0] tempReading,
    output logic doutPin,
    output logic [7:0] fieldOffset
);
    import smb_pkg::*;

    smb_core_s cReg;
    smb_core_s cNext;
    smb_nv_s nvReg;
    smb_nv_s nvNext;
    smb_link_s lReg;
    smb_link_s lNext;
    logic wrEvent;
    logic rdEvent;
    logic compSet;
    logic compClr;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic addrMatch;

    // The handshakes must finish well inside one bus bit at the fastest bus rate.
    if (`SMB_BIT_CYCLES < `SMB_XFER_CYCLES) begin : gRateCheck
        $error("Core clock too slow for the bus rate.");
    end

    // True for the nonvolatile parameter locations that are implemented.
    function automatic logic isParam(input logic [7:0] a);
        isParam = (a >= `SMB_LOC_LOWTHR) && (a <= `SMB_LOC_OFFSET);
    endfunction

    // True for every implemented location, volatile or not.
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a <= `SMB_LOC_RESTORE) || isParam(a);
    endfunction

    // Byte seen by a read of location a; one byte per location, no wider values.
    function automatic logic [7:0] readMux(input logic [7:0] a, input smb_nv_s n,
                                           input logic st, input logic [7:0] f,
                                           input logic [7:0] r, input logic [7:0] t);
        case (a)
            `SMB_LOC_CAL: readMux = f;
            `SMB_LOC_RAW: readMux = r;
            `SMB_LOC_TEMP: readMux = t;
            `SMB_LOC_DOUT: readMux = {7'h00, st};
            `SMB_LOC_ADDR: readMux = n.busAddr;
            `SMB_LOC_RESTORE: readMux = `SMB_RESTORE_READ;
            `SMB_LOC_LOWTHR: readMux = n.lowThr;
            `SMB_LOC_HIGHTHR: readMux = n.highThr;
            `SMB_LOC_HYSTERESIS: readMux = n.hysteresis;
            `SMB_LOC_INV: readMux = n.invert;
            `SMB_LOC_OFFSET: readMux = n.offset;
            default: readMux = `SMB_UNMAPPED;
        endcase
    endfunction

    // Events from the link: a toggle seen on the second synchroniser stage.
    assign wrEvent = cReg.wrSync[2] ^ cReg.wrSync[1];
    assign rdEvent = cReg.rdSync[2] ^ cReg.rdSync[1];

    // Comparator terms. Window mode is any upper threshold other than the unused code.
    // Release is computed one bit wider so a hysteresis above the threshold never releases.
    always_comb begin
        if (nvReg.highThr != `SMB_WINDOW_OFF) begin
            compSet = (calField < nvReg.lowThr) || (calField > nvReg.highThr);
            compClr = !compSet;
        end else begin
            compSet = calField > nvReg.lowThr;
            compClr = (nvReg.hysteresis != `SMB_LATCH_HYSTERESIS) &&
                      (({1'b0, calField} + {1'b0, nvReg.hysteresis}) < {1'b0, nvReg.lowThr});
        end
    end

    // Core-domain next state: strap capture, write and read requests, digital output.
    always_comb begin
        cNext = cReg;
        nvNext = nvReg;
        cNext.strapSync = {cReg.strapSync[0], addrSelPin};
        cNext.wrSync = {cReg.wrSync[1:0], lReg.wrReq};
        cNext.rdSync = {cReg.rdSync[1:0], lReg.rdReq};
        // The strap is caught once, after the synchroniser has filled, then frozen.
        if (!cReg.cfgReady) begin
            if (cReg.strapWait == `SMB_STRAP_WAIT) begin
                cNext.strapHigh = cReg.strapSync[1];
                cNext.activeAddr = cReg.strapSync[1] ? nvReg.busAddr
                                                     : `SMB_ALT_ADDR;
                cNext.cfgReady = 1'b1;
            end else begin
                cNext.strapWait = cReg.strapWait + 2'h1;
            end
        end
        // Comparator runs independently of bus traffic.
        if (compSet) begin
            cNext.doutState = 1'b1;
        end else if (compClr) begin
            cNext.doutState = 1'b0;
        end
        if (wrEvent) begin
            if (lReg.wrKind) begin
                cNext.ptr = lReg.wrByte;
            end else begin
                case (cReg.ptr)
                    // Clearing loses to a comparator set in the same cycle.
                    `SMB_LOC_DOUT: cNext.doutState = compSet;
                    `SMB_LOC_ADDR: nvNext.busAddr = lReg.wrByte;
                    `SMB_LOC_RESTORE: begin
                        // The stored bus address is deliberately left alone.
                        if (lReg.wrByte == `SMB_RESTORE_KEY) begin
                            nvNext.lowThr = `SMB_DEF_LOWTHR;
                            nvNext.highThr = `SMB_DEF_HIGHTHR;
                            nvNext.hysteresis = `SMB_DEF_HYSTERESIS;
                            nvNext.invert = `SMB_DEF_INV;
                            nvNext.offset = `SMB_DEF_OFFSET;
                        end
                    end
                    `SMB_LOC_LOWTHR: nvNext.lowThr = lReg.wrByte;
                    `SMB_LOC_HIGHTHR: nvNext.highThr = lReg.wrByte;
                    `SMB_LOC_HYSTERESIS: nvNext.hysteresis = lReg.wrByte;
                    `SMB_LOC_INV: nvNext.invert = lReg.wrByte;
                    `SMB_LOC_OFFSET: nvNext.offset = lReg.wrByte;
                    default: cNext.ptr = cReg.ptr;
                endcase
            end
        end
        // A read request snapshots the pointed byte; the pointer itself is untouched.
        if (rdEvent) begin
            cNext.rdData = readMux(cReg.ptr, nvReg, cReg.doutState, calField, rawField,
                                   tempReading);
            cNext.rdAck = !cReg.rdAck;
        end
        cNext.doutPin = cNext.doutState ^ nvNext.invert[0];
    end

    // Volatile core state; the output starts low and the pointer at location 0.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cReg <= '0;
            cReg.ptr <= `SMB_PTR_RESET;
            cReg.doutState <= 1'b0;
        end else begin
            cReg <= cNext;
        end
    end

    // Parameters have their own reset so that a power cycle keeps them.
    always_ff @(posedge core_clk or negedge nvRstn) begin
        if (!nvRstn) begin
            nvReg.busAddr <= `SMB_DEF_ADDR;
            nvReg.lowThr <= `SMB_DEF_LOWTHR;
            nvReg.highThr <= `SMB_DEF_HIGHTHR;
            nvReg.hysteresis <= `SMB_DEF_HYSTERESIS;
            nvReg.invert <= `SMB_DEF_INV;
            nvReg.offset <= `SMB_DEF_OFFSET;
        end else begin
            nvReg <= nvNext;
        end
    end

    // Bus conditions from the second synchroniser stage and its delayed copy.
    assign sclRise = lReg.sclSync[1] && !lReg.sclQ;
    assign sclFall = !lReg.sclSync[1] && lReg.sclQ;
    assign startCond = lReg.sclSync[1] && lReg.sclQ && lReg.sdaQ && !lReg.sdaSync[1];
    assign stopCond = lReg.sclSync[1] && lReg.sclQ && !lReg.sdaQ && lReg.sdaSync[1];
    // The active address is static once the synchronised ready flag is seen.
    assign addrMatch = lReg.rdySync[1] && (lReg.shift[7:1] == cReg.activeAddr[7:1]);

    // Link-domain next state: the byte-wide slave protocol.
    always_comb begin
        lNext = lReg;
        lNext.sclSync = {lReg.sclSync[0], sclIn};
        lNext.sdaSync = {lReg.sdaSync[0], sdaIn};
        lNext.sclQ = lReg.sclSync[1];
        lNext.sdaQ = lReg.sdaSync[1];
        lNext.rdySync = {lReg.rdySync[0], cReg.cfgReady};
        lNext.ackSync = {lReg.ackSync[1:0], cReg.rdAck};
        lNext.sdaOut = 1'b0;
        // Read data is stable in the core once its acknowledge toggle arrives.
        if (lReg.ackSync[2] ^ lReg.ackSync[1]) begin
            lNext.rdHold = cReg.rdData;
        end
        if (stopCond) begin
            lNext.st = LK_IDLE;
            lNext.sdaOe = 1'b0;
        end else if (startCond) begin
            lNext.st = LK_ADDR;
            lNext.cnt = 4'h0;
            lNext.firstByte = 1'b1;
            lNext.sdaOe = 1'b0;
        end else begin
            case (lReg.st)
                LK_ADDR, LK_WR: begin
                    if (sclRise) begin
                        lNext.shift = {lReg.shift[6:0], lReg.sdaSync[1]};
                        lNext.cnt = lReg.cnt + 4'h1;
                    end
                    if (sclFall && lReg.cnt == `SMB_BITS) begin
                        if (lReg.st == LK_WR) begin
                            lNext.sdaOe = 1'b1;
                            lNext.st = LK_WR_ACK;
                            lNext.wrReq = !lReg.wrReq;
                            lNext.wrKind = lReg.firstByte;
                            lNext.wrByte = lReg.shift;
                            lNext.firstByte = 1'b0;
                        end else if (addrMatch) begin
                            lNext.sdaOe = 1'b1;
                            lNext.st = LK_ADDR_ACK;
                            if (lReg.shift[0]) begin
                                lNext.rdReq = !lReg.rdReq;
                            end
                        end else begin
                            lNext.st = LK_IDLE;
                        end
                    end
                end
                LK_ADDR_ACK: begin
                    if (sclFall) begin
                        lNext.cnt = 4'h0;
                        if (lReg.shift[0]) begin
                            lNext.tx = lReg.rdHold;
                            lNext.sdaOe = !lReg.rdHold[7];
                            lNext.st = LK_RD;
                        end else begin
                            lNext.sdaOe = 1'b0;
                            lNext.st = LK_WR;
                        end
                    end
                end
                LK_WR_ACK: begin
                    if (sclFall) begin
                        lNext.sdaOe = 1'b0;
                        lNext.cnt = 4'h0;
                        lNext.st = LK_WR;
                    end
                end
                LK_RD: begin
                    if (sclFall) begin
                        lNext.tx = {lReg.tx[6:0], 1'b0};
                        lNext.cnt = lReg.cnt + 4'h1;
                        if (lReg.cnt == `SMB_BITS - 4'h1) begin
                            lNext.sdaOe = 1'b0;
                            lNext.st = LK_RD_ACK;
                        end else begin
                            lNext.sdaOe = !lReg.tx[6];
                        end
                    end
                end
                LK_RD_ACK: begin
                    // A master acknowledge asks for the same location again.
                    if (sclRise) begin
                        if (lReg.sdaSync[1]) begin
                            lNext.st = LK_IDLE;
                        end else begin
                            lNext.rdReq = !lReg.rdReq;
                        end
                    end
                    if (sclFall) begin
                        lNext.tx = lReg.rdHold;
                        lNext.sdaOe = !lReg.rdHold[7];
                        lNext.cnt = 4'h0;
                        lNext.st = LK_RD;
                    end
                end
                default: lNext.st = LK_IDLE;
            endcase
        end
    end

    // Link state; reset only loads constants and releases the data line.
    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            lReg <= '0;
            lReg.st <= LK_IDLE;
            lReg.sclSync <= 2'h3;
            lReg.sdaSync <= 2'h3;
            lReg.sclQ <= 1'b1;
            lReg.sdaQ <= 1'b1;
        end else begin
            lReg <= lNext;
        end
    end

    // Outputs are taken straight from registers.
    assign sdaOut = lReg.sdaOut;
    assign sdaOe = lReg.sdaOe;
    assign doutPin = cReg.doutPin;
    assign fieldOffset = nvReg.offset;

    // Named steps of a transfer, used by the link checks.
    sequence seqAddrDone;
        lReg.st == LK_ADDR && sclFall && lReg.cnt == `SMB_BITS && addrMatch && !stopCond
            && !startCond;
    endsequence
    sequence seqDataDone;
        lReg.st == LK_WR && sclFall && lReg.cnt == `SMB_BITS && !stopCond && !startCond;
    endsequence

    AST_ADDR_ACK: assert property (@(posedge linkClk) disable iff (!rstn)
        seqAddrDone |=> lReg.sdaOe && lReg.st == LK_ADDR_ACK)
        else $error("Matching address not acknowledged.");

    AST_WR_FIRST: assert property (@(posedge linkClk) disable iff (!rstn)
        seqDataDone |=> (lReg.wrReq != $past(lReg.wrReq)) && lReg.wrKind == $past(lReg.firstByte))
        else $error("Written byte not passed on with its kind.");

    AST_STRAP_ONCE: assert property (@(posedge core_clk) disable iff (!rstn)
        cReg.cfgReady |=> cReg.cfgReady && $stable(cReg.activeAddr))
        else $error("Active bus address changed after power-up.");

    AST_GROUND_ADDR: assert property (@(posedge core_clk) disable iff (!rstn)
        cReg.cfgReady && !cReg.strapHigh |-> cReg.activeAddr == `SMB_ALT_ADDR)
        else $error("Grounded strap did not force the alternate address.");

    AST_NV_ADDR: assert property (@(posedge core_clk) disable iff (!rstn)
        !cReg.cfgReady ##1 cReg.cfgReady && cReg.strapHigh
            |-> cReg.activeAddr == $past(nvReg.busAddr))
        else $error("High strap did not select the stored address.");

    AST_PTR_LOAD: assert property (@(posedge core_clk) disable iff (!rstn)
        wrEvent && lReg.wrKind |=> cReg.ptr == $past(lReg.wrByte))
        else $error("Address byte not loaded into the pointer.");

    AST_PTR_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        !(wrEvent && lReg.wrKind) |=> $stable(cReg.ptr))
        else $error("Pointer moved without an address write.");

    AST_UNMAPPED: assert property (@(posedge core_clk) disable iff (!rstn)
        rdEvent && !isMapped(cReg.ptr) |=> cReg.rdData == `SMB_UNMAPPED)
        else $error("Unimplemented location did not read as all ones.");

    AST_CAL_READ: assert property (@(posedge core_clk) disable iff (!rstn)
        rdEvent && cReg.ptr == `SMB_LOC_CAL |=> cReg.rdData == $past(calField))
        else $error("Location 0 did not return the calibrated field.");

    AST_DOUT_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn)
        wrEvent && !lReg.wrKind && cReg.ptr == `SMB_LOC_DOUT && !compSet |=> !cReg.doutState)
        else $error("Write to the output location did not clear it.");

    AST_RESTORE: assert property (@(posedge core_clk) disable iff (!rstn || !nvRstn)
        wrEvent && !lReg.wrKind && cReg.ptr == `SMB_LOC_RESTORE
            && lReg.wrByte == `SMB_RESTORE_KEY
        |=> nvReg.lowThr == `SMB_DEF_LOWTHR && nvReg.hysteresis == `SMB_DEF_HYSTERESIS
            && $stable(nvReg.busAddr))
        else $error("Factory restore did not reload the parameters.");

    AST_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
        cReg.doutState && nvReg.hysteresis == `SMB_LATCH_HYSTERESIS
            && nvReg.highThr == `SMB_WINDOW_OFF
            && !(wrEvent && !lReg.wrKind && cReg.ptr == `SMB_LOC_DOUT) |=> cReg.doutState)
        else $error("Latched output released without a clear.");

endmodule

// file: verification/smb_bus_master.sv
/* Bus master model: start, stop and nine-bit slots; assumes a pulled-up data wire. */
`timescale 1ns/100ps
module smb_bus_master (
    output logic sclIn,
    output logic sdaDrv,
    input wire logic sdaIn
);
    initial begin
        sclIn = 1'b1;
        sdaDrv = 1'b1;
    end
    // Start (data falls) or stop (data rises, clock left high) while the clock is high.
    task automatic frame(input logic isStart);
        #650 sdaDrv = isStart;
        #650 sclIn = 1'b1;
        #350 sdaDrv = ~isStart;
        #350 sclIn = ~isStart;
    endtask
    // Nine slots MSB first; low 1300 ns and high 700 ns keep within the 400 kHz limits.
    task automatic xfer(input logic [8:0] out, output logic [8:0] seen);
        for (int i = 8; i >= 0; i--) begin
            #650 sdaDrv = out[i];
            #650 sclIn = 1'b1;
            #350 seen[i] = sdaIn;
            #350 sclIn = 1'b0;
        end
    endtask
endmodule

// file: verification/tb.sv
/* Bench of the sensor bus slave: pointer, location map, address choice, output, restore.
   Assumes the bus master model beside it. */
`timescale 1ns/100ps
module tb;
    logic core_clk = 1'b0, linkClk = 1'b0, rstn = 1'b0, nvRstn = 1'b0, addrSelPin = 1'b1;
    logic sdaOut, sdaOe, doutPin, ack, sclIn, sdaDrv;
    logic [7:0] calField = 8'h37, rawField = 8'hc5, tempReading = 8'h19;
    logic [7:0] fieldOffset, rdVal, dev = 8'h48;
    logic [8:0] s;
    int fails = 0, check_count = 0;
    logic [15:0] map[10] = '{16'h0037, 16'h01c5, 16'h0219, 16'h0500, 16'h10ff, 16'h2064,
        16'h21ff, 16'h220a, 16'h2300, 16'h2400};
    // Open-drain data wire; when nobody pulls, the pull-up makes it high.
    wire logic sdaIn = sdaDrv & ~(sdaOe & ~sdaOut);
    // Core clock 25 ns; link clock 15 ns with an unrelated phase.
    initial forever #12.5 core_clk = ~core_clk;
    initial #4.1 forever #7.5 linkClk = ~linkClk;
    smb_sensor_bus_slave i_smb_sensor_bus_slave (.core_clk, .rstn, .nvRstn, .linkClk,
        .addrSelPin, .sclIn, .sdaIn, .sdaOut, .sdaOe, .calField, .rawField, .tempReading,
        .doutPin, .fieldOffset);
    smb_bus_master i_smb_bus_master (.sclIn, .sdaDrv, .sdaIn);
    task automatic check(input logic [7:0] seen, exp);
        check_count++;
        fails += int'(seen !== exp);
        if (seen !== exp) $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    endtask
    task automatic end_sim();
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // A read when bit 0 of a is set, else a pointer byte and maybe a data byte.
    task automatic xact(input logic [7:0] a, loc, d, input logic data);
        i_smb_bus_master.frame(1'b1);
        i_smb_bus_master.xfer({a, 1'b1}, s);
        ack = ~s[0];
        i_smb_bus_master.xfer(a[0] ? 9'h1ff : {loc, 1'b1}, s);
        rdVal = s[8:1];
        if (data) i_smb_bus_master.xfer({d, 1'b1}, s);
        i_smb_bus_master.frame(1'b0);
    endtask
    // Lone pointer byte, then a read that ends with no-acknowledge.
    task automatic peek(input logic [7:0] loc, exp);
        xact(dev, loc, 8'h00, 1'b0);
        xact(dev | 8'h01, 8'h00, 8'h00, 1'b0);
        check(rdVal, exp);
    endtask
    task automatic power(input logic sel);
        @(posedge core_clk);
        rstn <= 1'b0;
        addrSelPin <= sel;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        nvRstn <= 1'b1;
        repeat (12) @(posedge core_clk);
    endtask
    task automatic fieldTo(input logic [7:0] f, input logic e);
        @(posedge core_clk);
        calField <= f;
        for (int i = 0; i < 40 && doutPin !== e; i++) @(negedge core_clk);
        check({7'h0, doutPin}, {7'h0, e});
    endtask
    // Cycle ceiling well above the expected run length.
    initial begin
        repeat (95000) @(posedge core_clk);
        fails++;
        end_sim();
    end
    initial begin
        power(1'b1);
        check({7'h0, doutPin}, 8'h00);
        xact(dev | 8'h01, 8'h00, 8'h00, 1'b0);
        check({7'h0, ack}, 8'h01);
        check(rdVal, 8'h37);
        xact(dev | 8'h01, 8'h00, 8'h00, 1'b0);
        check(rdVal, 8'h37);
        xact(dev, 8'h10, 8'h99, 1'b1);
        foreach (map[i]) peek(map[i][15:8], map[i][7:0]);
        // A new stored address acts after power-up; a grounded strap overrides it.
        xact(dev, 8'h04, 8'h5c, 1'b1);
        power(1'b1);
        xact(8'h5d, 8'h00, 8'h00, 1'b0);
        check({7'h0, ack}, 8'h01);
        power(1'b0);
        addrSelPin <= 1'b1;
        dev = 8'h10;
        xact(8'h11, 8'h00, 8'h00, 1'b0);
        check({7'h0, ack}, 8'h01);
        xact(8'h5d, 8'h00, 8'h00, 1'b0);
        check({7'h0, ack}, 8'h00);
        // Output sets above threshold, latches with hysteresis 255, clears on a write.
        fieldTo(8'h80, 1'b1);
        xact(dev, 8'h22, 8'hff, 1'b1);
        fieldTo(8'h00, 1'b1);
        peek(8'h03, 8'h01);
        xact(dev, 8'h03, 8'h00, 1'b1);
        check({7'h0, doutPin}, 8'h00);
        // A latched output does not survive a power cycle.
        fieldTo(8'h80, 1'b1);
        fieldTo(8'h00, 1'b1);
        power(1'b0);
        check({7'h0, doutPin}, 8'h00);
        xact(dev, 8'h23, 8'h01, 1'b1);
        check({7'h0, doutPin}, 8'h01);
        xact(dev, 8'h24, 8'h5a, 1'b1);
        check(fieldOffset, 8'h5a);
        xact(dev, 8'h05, 8'h01, 1'b1);
        check(fieldOffset, 8'h00);
        check({7'h0, doutPin}, 8'h00);
        peek(8'h04, 8'h5c);
        peek(8'h22, 8'h0a);
        // Window mode: output high below the lower or above the upper threshold.
        xact(dev, 8'h21, 8'h90, 1'b1);
        check({7'h0, doutPin}, 8'h01);
        fieldTo(8'h70, 1'b0);
        fieldTo(8'ha0, 1'b1);
        end_sim();
    end
endmodule
